// ===== core/link_fmt_pkg.sv
`default_nettype none
package link_fmt_pkg;
   // register byte addresses on the wishbone slave
   localparam logic [3:0] OFS_FORMAT     = 4'h0;
   localparam logic [3:0] OFS_CLOCK_SEL  = 4'h4;
   localparam logic [3:0] OFS_STATUS     = 4'h8;
   localparam logic [7:0] FORMAT_RESET   = 8'h01;
   localparam logic [7:0] CLOCK_RESET    = 8'h00;
   // status layout
   localparam int STS_UNDERRUN = 0;
   localparam int STS_LINE     = 1;
   localparam int STS_MODE_LSB = 8;
   localparam int STS_FREQ_LSB = 16;
   // readout mode codes
   localparam logic [7:0] M_1T8   = 8'h00;
   localparam logic [7:0] M_1T10  = 8'h01;
   localparam logic [7:0] M_1T12  = 8'h02;
   localparam logic [7:0] M_1T16  = 8'h03;
   localparam logic [7:0] M_2T8   = 8'h04;
   localparam logic [7:0] M_2T10  = 8'h05;
   localparam logic [7:0] M_2T12  = 8'h06;
   localparam logic [7:0] M_4T8   = 8'h0a;
   localparam logic [7:0] M_4T10  = 8'h0b;
   localparam logic [7:0] M_4T12  = 8'h0c;
   localparam logic [7:0] M_4T16  = 8'h0d;
   localparam logic [7:0] M_8T8   = 8'h12;
   localparam logic [7:0] M_8T10  = 8'h13;
   localparam logic [7:0] M_10T8  = 8'h14;
   localparam logic [7:0] M_SERIAL = 8'hfe;
   localparam logic [7:0] M_USB    = 8'hff;
   // link clock frequencies in units of 100 kHz, per clock code 0..3
   localparam logic [15:0] FREQ_SMALL [4] = '{16'h014a, 16'h01a9, 16'h0294, 16'h0352};
   localparam logic [15:0] FREQ_LARGE [4] = '{16'h012c, 16'h01a9, 16'h0258, 16'h0352};
   localparam int BLOCK_PIX = 10;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_HOLD = 3'b100
   } out_state_e;
endpackage : link_fmt_pkg
`default_nettype wire

// ===== core/tap_packer.sv
`default_nettype none
// holds up to two ten-pixel blocks, each pixel tagged with its block's line/frame flags
module tap_packer #(
   parameter int PW    = 16,
   parameter int BLK   = 10,
   parameter int DEPTH = 20
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic [BLK*PW-1:0] blkPix,
   input  wire logic              blkLval,
   input  wire logic              blkFval,
   input  wire logic              blkValid,
   output logic                   blkReady,
   input  wire logic [4:0]        popN,
   output logic [4:0]             level,
   output logic [BLK*PW-1:0]      headPix,
   output logic                   headLval,
   output logic                   headFval
);
   logic [PW+1:0] buf_ff [DEPTH];
   logic [PW+1:0] nxt_buf [DEPTH];
   logic [4:0]    count_ff;
   logic [4:0]    nxt_count;
   logic          ready_ff;
   logic          load;

   assign load     = blkValid & ready_ff;
   assign blkReady = ready_ff;
   assign level    = count_ff;
   assign headLval = buf_ff[0][PW];
   assign headFval = buf_ff[0][PW+1];
   assign nxt_count = count_ff - popN + (load ? 5'(BLK) : 5'h00);

   always_comb
   begin
      int keep;
      int j;
      keep = int'(count_ff) - int'(popN);
      j    = 0;
      for (int i = 0; i < DEPTH; i++)
      begin
         j = i - keep;
         if (i < keep)
            nxt_buf[i] = buf_ff[i + int'(popN)];
         else if (load && j >= 0 && j < BLK)
            nxt_buf[i] = {blkFval, blkLval, blkPix[j*PW +: PW]};
         else
            nxt_buf[i] = '0;
      end
   end

   always_comb
   begin
      for (int i = 0; i < BLK; i++)
         headPix[i*PW +: PW] = buf_ff[i][PW-1:0];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_ff <= 5'h00;
         ready_ff <= 1'b0;
         for (int i = 0; i < DEPTH; i++)
            buf_ff[i] <= '0;
      end
      else
      begin
         count_ff <= nxt_count;
         // registered so a block is never offered space the pop has not freed yet
         ready_ff <= (nxt_count <= 5'(DEPTH - BLK));
         for (int i = 0; i < DEPTH; i++)
            buf_ff[i] <= nxt_buf[i];
      end
   end
endmodule : tap_packer
`default_nettype wire

// ===== core/camera_link_tap_formatter.sv
// The Wishbone slave port and the address map were decided locally.
`default_nettype none
module camera_link_tap_formatter #(
   parameter int PW            = 16,
   parameter int START_FILL    = 10,
   parameter bit LARGE_VARIANT = 1'b0
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [3:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic [10*PW-1:0] blkPix,
   input  wire logic         blkLval,
   input  wire logic         blkFval,
   input  wire logic         blkValid,
   output logic              blkReady,
   input  wire logic         linkClk,
   output logic [1:0]        linkClkSel,
   output logic [23:0]       firstChanPorts,
   output logic [23:0]       secondChanPorts,
   output logic [23:0]       thirdChanPorts,
   output logic [27:0]       firstChanTx,
   output logic [27:0]       secondChanTx,
   output logic [27:0]       thirdChanTx,
   output logic              txDirect,
   output logic              linkLval,
   output logic              linkFval,
   output logic              linkDval,
   output logic              serialRoute,
   output logic              usbRoute
);
   function automatic logic isSupported(input logic [7:0] m);
      case (m)
         link_fmt_pkg::M_1T8, link_fmt_pkg::M_1T10, link_fmt_pkg::M_1T12,
         link_fmt_pkg::M_1T16, link_fmt_pkg::M_2T8, link_fmt_pkg::M_2T10,
         link_fmt_pkg::M_2T12, link_fmt_pkg::M_4T8, link_fmt_pkg::M_4T10,
         link_fmt_pkg::M_4T12, link_fmt_pkg::M_4T16, link_fmt_pkg::M_8T8,
         link_fmt_pkg::M_8T10, link_fmt_pkg::M_10T8, link_fmt_pkg::M_SERIAL,
         link_fmt_pkg::M_USB: isSupported = 1'b1;
         default:             isSupported = 1'b0;
      endcase
   endfunction : isSupported

   function automatic logic [4:0] tapsOf(input logic [7:0] m);
      case (m)
         link_fmt_pkg::M_1T8, link_fmt_pkg::M_1T10,
         link_fmt_pkg::M_1T12, link_fmt_pkg::M_1T16: tapsOf = 5'h01;
         link_fmt_pkg::M_2T8, link_fmt_pkg::M_2T10, link_fmt_pkg::M_2T12: tapsOf = 5'h02;
         link_fmt_pkg::M_4T8, link_fmt_pkg::M_4T10,
         link_fmt_pkg::M_4T12, link_fmt_pkg::M_4T16: tapsOf = 5'h04;
         link_fmt_pkg::M_8T8, link_fmt_pkg::M_8T10: tapsOf = 5'h08;
         link_fmt_pkg::M_10T8: tapsOf = 5'h0a;
         default: tapsOf = 5'h00;
      endcase
   endfunction : tapsOf

   logic [7:0]  format_ff;
   logic [7:0]  clockSel_ff;
   logic [7:0]  activeMode_ff;
   logic [1:0]  activeClk_ff;
   logic        ack_ff;
   logic [31:0] rdat_ff;
   logic        underrun_ff;
   logic        linkS1_ff;
   logic        linkS2_ff;
   logic        linkS3_ff;
   link_fmt_pkg::out_state_e state_ff;
   link_fmt_pkg::out_state_e nxt_state;
   logic [4:0]  popN;
   logic [4:0]  level;
   logic [10*PW-1:0] headPix;
   logic        headLval;
   logic        headFval;
   logic        blkReadyInt;
   logic [71:0] portsWord;
   logic [83:0] txWord;
   logic [71:0] ports_ff;
   logic [83:0] tx_ff;
   logic        txDirect_ff;
   logic        lval_ff;
   logic        fval_ff;
   logic        serial_ff;
   logic        usb_ff;

   wire        wbReq     = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire        wbWrite   = wbReq & wb_we_i & wb_sel_i[0];
   wire        wrFormat  = wbWrite & (wb_adr_i == link_fmt_pkg::OFS_FORMAT);
   wire        wrClock   = wbWrite & (wb_adr_i == link_fmt_pkg::OFS_CLOCK_SEL);
   wire        wrStatus  = wbWrite & (wb_adr_i == link_fmt_pkg::OFS_STATUS);
   wire        tick      = linkS2_ff & ~linkS3_ff;
   wire [4:0]  taps      = tapsOf(activeMode_ff);
   wire        betweenFrames = (state_ff == link_fmt_pkg::ST_IDLE) & ~fval_ff & ~headFval;
   wire [4:0]  dropN     = (level > 5'(link_fmt_pkg::BLOCK_PIX)) ? 5'(link_fmt_pkg::BLOCK_PIX)
                                                                 : level;
   wire        canStart  = headLval & (level >= 5'(START_FILL)) & (taps != 5'h00);
   wire        canSend   = headLval & (level >= taps);
   wire        setUnder  = tick & (state_ff == link_fmt_pkg::ST_SEND) & headLval & ~canSend;
   wire [15:0] freqCode  = LARGE_VARIANT ? link_fmt_pkg::FREQ_LARGE[activeClk_ff]
                                         : link_fmt_pkg::FREQ_SMALL[activeClk_ff];
   wire [31:0] statusWord = {freqCode, activeMode_ff, 6'h00,
                             (state_ff == link_fmt_pkg::ST_SEND), underrun_ff};
   wire [31:0] rdMux = (wb_adr_i == link_fmt_pkg::OFS_FORMAT)    ? {24'h000000, format_ff} :
                       (wb_adr_i == link_fmt_pkg::OFS_CLOCK_SEL) ? {24'h000000, clockSel_ff} :
                       (wb_adr_i == link_fmt_pkg::OFS_STATUS)    ? statusWord : 32'h00000000;

   // pixel letters a..k as 16-bit slices of the head block
   wire [15:0] pa = headPix[0*PW +: 16];
   wire [15:0] pb = headPix[1*PW +: 16];
   wire [15:0] pc = headPix[2*PW +: 16];
   wire [15:0] pd = headPix[3*PW +: 16];
   wire [15:0] pe = headPix[4*PW +: 16];
   wire [15:0] pf = headPix[5*PW +: 16];
   wire [15:0] pg = headPix[6*PW +: 16];
   wire [15:0] ph = headPix[7*PW +: 16];
   wire [15:0] pj = headPix[8*PW +: 16];
   wire [15:0] pk = headPix[9*PW +: 16];

   tap_packer #(
      .PW    (PW),
      .BLK   (link_fmt_pkg::BLOCK_PIX),
      .DEPTH (2 * link_fmt_pkg::BLOCK_PIX)
   ) u_packer (
      .clk      (clk),
      .reset_n  (reset_n),
      .blkPix   (blkPix),
      .blkLval  (blkLval),
      .blkFval  (blkFval),
      .blkValid (blkValid),
      .blkReady (blkReadyInt),
      .popN     (popN),
      .level    (level),
      .headPix  (headPix),
      .headLval (headLval),
      .headFval (headFval)
   );

   // port word packs ch3 C,B,A | ch2 C,B,A | ch1 C,B,A, each byte A lowest
   always_comb
   begin
      portsWord = 72'h0;
      txWord    = 84'h0;
      case (activeMode_ff)
         link_fmt_pkg::M_1T8:  portsWord[7:0] = pa[7:0];
         link_fmt_pkg::M_1T10: portsWord[15:0] = {6'h00, pa[9:0]};
         link_fmt_pkg::M_1T12: portsWord[15:0] = {4'h0, pa[11:0]};
         link_fmt_pkg::M_1T16: portsWord[15:0] = pa;
         link_fmt_pkg::M_2T8:  portsWord[15:0] = {pb[7:0], pa[7:0]};
         link_fmt_pkg::M_2T10:
            portsWord[23:0] = {pb[7:0], 2'b00, pb[9:8], 2'b00, pa[9:8], pa[7:0]};
         link_fmt_pkg::M_2T12:
            portsWord[23:0] = {pb[7:0], pb[11:8], pa[11:8], pa[7:0]};
         link_fmt_pkg::M_4T8:
            portsWord[31:0] = {pd[7:0], pc[7:0], pb[7:0], pa[7:0]};
         link_fmt_pkg::M_4T10:
            portsWord[47:0] = {2'b00, pd[9:8], 2'b00, pc[9:8], pc[7:0], pd[7:0],
                               pb[7:0], 2'b00, pb[9:8], 2'b00, pa[9:8], pa[7:0]};
         link_fmt_pkg::M_4T12:
            portsWord[47:0] = {pd[11:8], pc[11:8], pc[7:0], pd[7:0],
                               pb[7:0], pb[11:8], pa[11:8], pa[7:0]};
         link_fmt_pkg::M_4T16:
            portsWord[63:0] = {pd, pc, pb, pa};
         link_fmt_pkg::M_8T8:
            portsWord[63:0] = {ph[7:0], pg[7:0], pf[7:0], pe[7:0],
                               pd[7:0], pc[7:0], pb[7:0], pa[7:0]};
         link_fmt_pkg::M_8T10:
         begin
            txWord[27:0]  = {pc[5:4], 1'b0, 1'b1, pc[3:0], pb[9:0], pa[9:0]};
            txWord[55:28] = {1'b1, pf[2:0], pe[9:0], pd[9:0], pc[9:6]};
            txWord[83:56] = {1'b1, ph[9:0], pg[9:0], pf[9:3]};
         end
         link_fmt_pkg::M_10T8:
         begin
            txWord[27:0]  = {pd[1:0], 1'b0, 1'b1, pc[7:0], pb[7:0], pa[7:0]};
            txWord[55:28] = {1'b1, pg[4:0], pf[7:0], pe[7:0], pd[7:2]};
            txWord[83:56] = {1'b1, pk[7:0], pj[7:0], ph[7:0], pg[7:5]};
         end
         default:
         begin
            portsWord = 72'h0;
            txWord    = 84'h0;
         end
      endcase
      // frame valid in the direct modes follows the head block flag
      txWord[25] = txWord[24] & headFval;
   end

   always_comb
   begin
      nxt_state = state_ff;
      popN      = 5'h00;
      case (state_ff)
         link_fmt_pkg::ST_IDLE:
            if (tick)
            begin
               if (level != 5'h00 && !headLval)
                  popN = dropN;
               else if (canStart)
                  nxt_state = link_fmt_pkg::ST_SEND;
            end
         link_fmt_pkg::ST_SEND:
            if (tick)
            begin
               if (canSend)
                  popN = taps;
               else if (!headLval && level != 5'h00)
                  nxt_state = link_fmt_pkg::ST_HOLD;
            end
         link_fmt_pkg::ST_HOLD:
            nxt_state = link_fmt_pkg::ST_IDLE;
         default:
            nxt_state = link_fmt_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         linkS1_ff <= 1'b0;
         linkS2_ff <= 1'b0;
         linkS3_ff <= 1'b0;
      end
      else
      begin
         linkS1_ff <= linkClk;
         linkS2_ff <= linkS1_ff;
         linkS3_ff <= linkS2_ff;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         format_ff   <= link_fmt_pkg::FORMAT_RESET;
         clockSel_ff <= link_fmt_pkg::CLOCK_RESET;
         underrun_ff <= 1'b0;
         ack_ff      <= 1'b0;
         rdat_ff     <= 32'h00000000;
      end
      else
      begin
         ack_ff  <= wbReq;
         rdat_ff <= wbReq ? rdMux : 32'h00000000;
         if (wrFormat && isSupported(wb_dat_i[7:0]))
            format_ff <= wb_dat_i[7:0];
         if (wrClock)
            clockSel_ff <= {6'h00, wb_dat_i[1:0]};
         // a new underrun in the clearing cycle wins over the clear
         if (setUnder)
            underrun_ff <= 1'b1;
         else if (wrStatus && wb_dat_i[link_fmt_pkg::STS_UNDERRUN])
            underrun_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff      <= link_fmt_pkg::ST_IDLE;
         activeMode_ff <= link_fmt_pkg::FORMAT_RESET;
         activeClk_ff  <= 2'b00;
      end
      else
      begin
         state_ff    <= nxt_state;
         if (betweenFrames)
         begin
            activeMode_ff <= format_ff;
            activeClk_ff  <= clockSel_ff[1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ports_ff    <= 72'h0;
         tx_ff       <= 84'h0;
         txDirect_ff <= 1'b0;
         lval_ff     <= 1'b0;
         fval_ff     <= 1'b0;
         serial_ff   <= 1'b0;
         usb_ff      <= 1'b0;
      end
      else
      begin
         serial_ff <= (activeMode_ff == link_fmt_pkg::M_SERIAL);
         usb_ff    <= (activeMode_ff == link_fmt_pkg::M_USB);
         txDirect_ff <= (activeMode_ff == link_fmt_pkg::M_8T10) |
                        (activeMode_ff == link_fmt_pkg::M_10T8);
         if (tick)
         begin
            // on underrun the last word and line valid are held rather than torn
            if (state_ff == link_fmt_pkg::ST_SEND && canSend)
            begin
               ports_ff <= portsWord;
               tx_ff    <= txWord;
               lval_ff  <= 1'b1;
               fval_ff  <= headFval;
            end
            else if (!(state_ff == link_fmt_pkg::ST_SEND && headLval))
            begin
               tx_ff   <= 84'h0;
               lval_ff <= 1'b0;
               fval_ff <= (level != 5'h00) & headFval;
            end
         end
      end
   end

   assign wb_ack_o        = ack_ff;
   assign wb_dat_o        = rdat_ff;
   // ready is the packer's own flop, so what the source sees is what gates the load
   assign blkReady        = blkReadyInt;
   assign linkClkSel      = activeClk_ff;
   assign firstChanPorts  = ports_ff[23:0];
   assign secondChanPorts = ports_ff[47:24];
   assign thirdChanPorts  = ports_ff[71:48];
   assign firstChanTx     = tx_ff[27:0];
   assign secondChanTx    = tx_ff[55:28];
   assign thirdChanTx     = tx_ff[83:56];
   assign txDirect        = txDirect_ff;
   assign linkLval        = lval_ff;
   assign linkFval        = fval_ff;
   assign linkDval        = 1'b0;
   assign serialRoute     = serial_ff;
   assign usbRoute        = usb_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   a_ack_timing: assert property (s_req |=> s_ack_pulse)
      else $error("ack not one cycle after request");
   a_bad_mode_kept: assert property (wrFormat && !isSupported(wb_dat_i[7:0]) |=> $stable(format_ff))
      else $error("unsupported mode code stored");
   a_mode_between: assert property ($changed(activeMode_ff) |-> $past(state_ff) == link_fmt_pkg::ST_IDLE && !$past(fval_ff))
      else $error("mode changed inside a frame");
   a_route_serial: assert property (activeMode_ff == link_fmt_pkg::M_SERIAL |=> serialRoute && !usbRoute)
      else $error("serial routing not selected");
   a_no_dval: assert property (!linkDval)
      else $error("data valid driven");
   a_one_tap8: assert property (tick && state_ff == link_fmt_pkg::ST_SEND && canSend && activeMode_ff == link_fmt_pkg::M_1T8 |=> firstChanPorts[7:0] == $past(pa[7:0]) && linkLval)
      else $error("single tap byte not on port A");
   a_ten_tap_lval: assert property (txDirect && linkLval && activeMode_ff == link_fmt_pkg::M_10T8 |-> secondChanTx[27] && thirdChanTx[27] && firstChanTx[24])
      else $error("line valid missing on tx bits");
   a_start_fill: assert property ($rose(state_ff == link_fmt_pkg::ST_SEND) |-> $past(level) >= 5'(START_FILL))
      else $error("line started without enough pixels");
   a_freq_code: assert property (activeClk_ff == 2'b10 |-> freqCode == (LARGE_VARIANT ? 16'h0258 : 16'h0294))
      else $error("clock code readback wrong");
   a_line_end: assert property (tick && state_ff == link_fmt_pkg::ST_SEND && !headLval && level != 5'h00 |=> !linkLval ##1 state_ff == link_fmt_pkg::ST_IDLE)
      else $error("line valid not dropped at line end");
endmodule : camera_link_tap_formatter
`default_nettype wire

// ===== tb/grabber_model.sv
`default_nettype none
module grabber_model (
   output var logic        linkClk,
   input  wire logic       clk,
   input  wire logic       linkLval,
   input  wire logic [47:0] chanPorts,
   input  wire logic [27:0] chanTx,
   output var logic [7:0]  lines,
   output var logic [63:0] word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lvalDly = 1'b0;
   // link clock runs free, as a grabber sees it between frames too
   initial
   begin
      linkClk = 1'b0;
      forever #40 linkClk = ~linkClk;
   end
   initial lines = 8'h0;
   // keep only the first word of each line; later words are not compared
   always @(posedge clk)
   begin
      lvalDly <= linkLval;
      if (linkLval && !lvalDly)
      begin
         lines <= lines + 8'h1;
         word <= {chanTx, chanPorts[35:0]};
      end
   end
endmodule : grabber_model
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, blkLval, blkFval, blkValid;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, rd;
   logic [159:0] blkPix;
   wire logic [31:0] wb_dat_o;
   wire logic wb_ack_o, blkReady, linkClk, txDirect, linkLval, linkFval, linkDval;
   wire logic serialRoute, usbRoute;
   wire logic [1:0] linkClkSel;
   wire logic [23:0] firstChanPorts, secondChanPorts, thirdChanPorts;
   wire logic [27:0] firstChanTx, secondChanTx, thirdChanTx;
   wire logic [7:0] lines;
   wire logic [63:0] word;
   int num_errors, compares, k, n;
   logic dir;
   logic [7:0] mode;
   logic [63:0] mask, expv;
   localparam logic [63:0] MT = 64'hfffffff_000000000;
   logic [15:0] fq [4] = '{16'h014a, 16'h01a9, 16'h0294, 16'h0352};
   logic [136:0] rows [14] = '{{1'b0, 8'h00, 64'hff, 64'h30},
      {1'b0, 8'h02, 64'hfff, 64'ha30},
      {1'b0, 8'h06, 64'hffffff, 64'h41ba30},
      {1'b0, 8'h0b, 64'hfffff33ff, 64'h263413230},
      {1'b0, 8'h0c, 64'hfffffffff, 64'h26341ba30},
      {1'b0, 8'h0d, 64'hfffffffff, 64'h26b415a30},
      {1'b0, 8'h12, 64'hfffffffff, 64'h463524130},
      {1'b0, 8'h01, 64'h3ff, 64'h230}, {1'b0, 8'h03, 64'hffff, 64'h5a30},
      {1'b0, 8'h04, 64'hffff, 64'h4130}, {1'b0, 8'h05, 64'hff33ff, 64'h413230},
      {1'b0, 8'h0a, 64'hffffffff, 64'h63524130},
      {1'b1, 8'h13, MT, 64'h72d0630_000000000}, {1'b1, 8'h14, MT, 64'hf524130_000000000}};
   camera_link_tap_formatter dut_u (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .blkPix, .blkLval, .blkFval,
      .blkValid, .blkReady, .linkClk, .linkClkSel, .firstChanPorts, .secondChanPorts,
      .thirdChanPorts, .firstChanTx, .secondChanTx, .thirdChanTx, .txDirect, .linkLval,
      .linkFval, .linkDval, .serialRoute, .usbRoute);
   grabber_model partner_u (.linkClk, .clk, .linkLval, .lines, .word,
      .chanPorts({secondChanPorts, firstChanPorts}), .chanTx(firstChanTx));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do
      begin
         @(posedge clk);
         c++;
      end
      while (wb_ack_o !== 1'b1 && c < 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (c >= 20) num_errors++;
   endtask : wb
   // wait until the active copy of a register shows in status
   task automatic poll(input int lsb, input logic [15:0] m, input logic [15:0] v);
      k = 0;
      do
      begin
         wb(1'b0, 4'h8, 32'h0);
         k++;
      end
      while ((rd[lsb+:16] & m) !== v && k < 60);
      if (k >= 60) num_errors++;
   endtask : poll
   task automatic push(input logic lv, input logic fv);
      int c;
      c = 0;
      @(posedge clk);
      {blkLval, blkFval, blkValid} <= {lv, fv, 1'b1};
      do
      begin
         @(posedge clk);
         c++;
      end
      while (blkReady !== 1'b1 && c < 3000);
      blkValid <= 1'b0;
      if (c >= 3000) num_errors++;
   endtask : push
   task automatic results;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #200000;
      num_errors++;
      results();
   end
   initial
   begin
      {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, blkLval, blkFval, blkValid} = 7'h0;
      {wb_adr_i, wb_dat_i, wb_sel_i} = {36'h0, 4'hf};
      for (int i = 0; i < 10; i++) blkPix[i*16+:16] = 16'h5a30 + 16'h1111 * i;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h01);
      wb(1'b1, 4'h0, 32'h07);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h01);
      wb(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0);
      for (int c = 3; c >= 0; c--)
      begin
         wb(1'b1, 4'h4, c);
         poll(16, 16'hffff, fq[c]);
         chk(rd[31:16], fq[c]);
         chk(linkClkSel, c);
      end
      wb(1'b1, 4'h0, 32'hfe);
      poll(8, 16'h00ff, 16'hfe);
      chk({serialRoute, usbRoute}, 2'b10);
      wb(1'b1, 4'h0, 32'hff);
      poll(8, 16'h00ff, 16'hff);
      chk({serialRoute, usbRoute}, 2'b01);
      foreach (rows[r])
      begin
         {dir, mode, mask, expv} = rows[r];
         wb(1'b1, 4'h0, {24'h0, mode});
         poll(8, 16'h00ff, {8'h0, mode});
         n = lines;
         push(1'b1, 1'b1);
         push(1'b0, 1'b1);
         push(1'b0, 1'b0);
         for (k = 0; k < 3000 && lines == n; k++) @(posedge clk);
         chk(lines, n + 1);
         chk(word & mask, expv);
         chk({txDirect, linkDval}, {dir, 1'b0});
      end
      // reset in mid-run: outputs clear and the format register returns to default
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({linkLval, linkFval, txDirect, wb_ack_o, blkReady, linkClkSel}, 7'h00);
      reset_n <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h01);
      results();
   end
endmodule : tb
`default_nettype wire
